//--- xt_host_status_handshake.sv
`timescale 1ns/100ps
`default_nettype none
module xt_host_status_handshake #(
  parameter int DW = 8
) (
  // clock and resets
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic host_reset_input,
  // mode select from the host mode control register
  input wire logic xt_mode_select,
  // host bus pins
  input wire logic host_cs_n,
  input wire logic host_dack_n,
  input wire logic [1:0] host_addr,
  input wire logic host_ior_n,
  input wire logic host_iow_n,
  input wire logic [DW-1:0] host_data_in,
  output logic [DW-1:0] host_data_out,
  output logic host_data_oe_n,
  output logic host_dreq,
  output logic host_interrupt_output,
  // local microcontroller side
  input wire logic uc_phase_load,
  input wire logic [1:0] uc_phase_sel,
  input wire logic uc_byte_ready,
  input wire logic uc_cmd_done,
  output logic uc_cmd_start,
  output logic uc_byte_taken,
  output logic uc_host_abort,
  output logic uc_drive_select,
  output logic [DW-1:0] uc_host_wdata
);

  xt_host_pkg::host_bus_s bus;
  xt_host_pkg::host_evt_s evt_raw;
  xt_host_pkg::host_evt_s evt;
  logic [DW-1:0] wdata_q;

  xt_host_pkg::phase_e phase_r;
  xt_host_pkg::phase_e phase_nxt;
  logic req_r;
  logic req_nxt;
  logic irq_r;
  logic irq_nxt;
  logic [2:0] enable_r;
  logic [2:0] enable_nxt;
  logic [DW-1:0] rdata_r;
  logic cmd_start_r;
  logic byte_taken_r;
  logic abort_r;
  logic [DW-1:0] uc_wdata_r;

  assign bus.cs_n = host_cs_n;
  assign bus.dack_n = host_dack_n;
  assign bus.addr = host_addr;
  assign bus.ior_n = host_ior_n;
  assign bus.iow_n = host_iow_n;

  host_port_decode #(
    .DW(DW)
  ) u_decode (
    .sys_clk(sys_clk),
    .rst(rst),
    .bus(bus),
    .wdata(host_data_in),
    .evt(evt_raw),
    .wdata_r(wdata_q)
  );

  // all host port activity is ignored outside xt mode
  assign evt = xt_mode_select ? evt_raw : '0;

  // phase code fields
  wire busy = phase_r[2];
  wire cd_flag = phase_r[1];
  wire io_flag = phase_r[0];
  wire dma_en = enable_r[xt_host_pkg::EN_DMA_BIT];
  wire int_en = enable_r[xt_host_pkg::EN_INT_BIT];

  // a byte ends on a port 0 or a dma access, alike
  wire byte_xfer = req_r & (evt.data_rd | evt.data_wr);
  wire hard_reset = rst | host_reset_input;
  wire prog_reset = evt.reset_wr;

  // select only counts while idle
  wire cmd_start = evt.select_wr & ~busy;
  wire enable_clr_int = evt.enable_wr
                        & ~wdata_q[xt_host_pkg::EN_INT_BIT];

  function automatic xt_host_pkg::phase_e phase_of(input logic [1:0] sel);
    unique case (sel)
      2'b00: phase_of = xt_host_pkg::PH_DATA_IN;
      2'b01: phase_of = xt_host_pkg::PH_DATA_OUT;
      2'b10: phase_of = xt_host_pkg::PH_COMMAND;
      2'b11: phase_of = xt_host_pkg::PH_STATUS;
    endcase
  endfunction

  // phase sequencing; program reset beats everything local
  always_comb
  begin
    phase_nxt = phase_r;
    unique case (phase_r)
      xt_host_pkg::PH_IDLE:
      begin
        if (cmd_start)
          phase_nxt = xt_host_pkg::PH_COMMAND;
      end
      xt_host_pkg::PH_DATA_IN,
      xt_host_pkg::PH_DATA_OUT,
      xt_host_pkg::PH_COMMAND,
      xt_host_pkg::PH_STATUS:
      begin
        if (uc_cmd_done)
          phase_nxt = xt_host_pkg::PH_IDLE;
        else if (uc_phase_load)
          phase_nxt = phase_of(uc_phase_sel);
      end
      default: phase_nxt = xt_host_pkg::PH_IDLE;
    endcase
    if (prog_reset)
      phase_nxt = xt_host_pkg::PH_IDLE;
  end

  // byte request: set per byte, cleared by the transfer; set wins
  always_comb
  begin
    req_nxt = req_r;
    if (byte_xfer)
      req_nxt = 1'b0;
    if (uc_byte_ready & busy)
      req_nxt = 1'b1;
    if (prog_reset | uc_cmd_done | ~busy)
      req_nxt = 1'b0;
  end

  // dreq is the pending data byte, gated by enable, dropped on dack
  assign host_dreq = req_r & busy & ~cd_flag & dma_en
                     & xt_mode_select & host_dack_n;

  // interrupt is sticky from the status byte until one of its clears
  wire irq_set = int_en & (phase_r == xt_host_pkg::PH_STATUS)
                 & req_r;
  wire irq_clr = enable_clr_int | prog_reset;

  always_comb
  begin
    irq_nxt = irq_r;
    if (irq_clr)
      irq_nxt = 1'b0;
    else if (irq_set)
      irq_nxt = 1'b1;
  end

  always_comb
  begin
    enable_nxt = enable_r;
    if (evt.enable_wr)
      enable_nxt = wdata_q[2:0];
  end

  // live status byte
  wire [DW-1:0] status_byte = {
    xt_host_pkg::STATUS_RESERVED,
    irq_r,
    host_dreq,
    busy,
    cd_flag,
    io_flag,
    req_r
  };

  always_ff @(posedge sys_clk)
  begin
    if (hard_reset)
    begin
      phase_r <= xt_host_pkg::PH_IDLE;
      req_r <= 1'b0;
      irq_r <= 1'b0;
      enable_r <= xt_host_pkg::ENABLE_RESET;
    end
    else
    begin
      phase_r <= phase_nxt;
      req_r <= req_nxt;
      irq_r <= irq_nxt;
      enable_r <= enable_nxt;
    end
  end

  // host read data and local side pulses
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      rdata_r <= '0;
      cmd_start_r <= 1'b0;
      byte_taken_r <= 1'b0;
      abort_r <= 1'b0;
      uc_wdata_r <= '0;
    end
    else
    begin
      rdata_r <= status_byte;
      cmd_start_r <= cmd_start & ~prog_reset;
      byte_taken_r <= byte_xfer & ~prog_reset;
      abort_r <= prog_reset | host_reset_input;
      if (evt.data_wr | evt.select_wr)
        uc_wdata_r <= wdata_q;
    end
  end

  assign host_data_out = rdata_r;
  assign host_data_oe_n = ~evt.status_rd;
  assign host_interrupt_output = irq_r;
  assign uc_cmd_start = cmd_start_r;
  assign uc_byte_taken = byte_taken_r;
  assign uc_host_abort = abort_r;
  assign uc_drive_select = enable_r[xt_host_pkg::EN_DRV_BIT];
  assign uc_host_wdata = uc_wdata_r;

endmodule
`default_nettype wire

//--- xt_host_pkg.sv
package xt_host_pkg;

  // host port addresses on a1:a0
  localparam logic [1:0] PORT_DATA = 2'h0;
  localparam logic [1:0] PORT_STATUS = 2'h1;
  localparam logic [1:0] PORT_SELECT = 2'h2;
  localparam logic [1:0] PORT_ENABLE = 2'h3;

  // status bit positions
  localparam int REQ_BIT = 0;
  localparam int IO_BIT = 1;
  localparam int CD_BIT = 2;
  localparam int BUSY_BIT = 3;
  localparam int DMA_REQUEST_FLAG_BIT = 4;
  localparam int HOST_INTERRUPT_FLAG_BIT = 5;
  localparam logic [1:0] STATUS_RESERVED = 2'h0;

  // enable port bit positions and reset value
  localparam int EN_DMA_BIT = 0;
  localparam int EN_INT_BIT = 1;
  localparam int EN_DRV_BIT = 2;
  localparam logic [2:0] ENABLE_RESET = 3'h0;

  // phase code is {busy, command/data, direction}
  typedef enum logic [2:0] {
    PH_IDLE = 3'b000,
    PH_DATA_IN = 3'b100,
    PH_DATA_OUT = 3'b101,
    PH_COMMAND = 3'b110,
    PH_STATUS = 3'b111
  } phase_e;

  typedef struct packed {
    logic cs_n;
    logic dack_n;
    logic [1:0] addr;
    logic ior_n;
    logic iow_n;
  } host_bus_s;

  typedef struct packed {
    logic data_rd;
    logic data_wr;
    logic reset_wr;
    logic select_wr;
    logic enable_wr;
    logic status_rd;
  } host_evt_s;

endpackage

//--- host_port_decode.sv
`timescale 1ns/100ps
`default_nettype none
module host_port_decode #(
  parameter int DW = 8
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // host pins
  input wire xt_host_pkg::host_bus_s bus,
  input wire logic [DW-1:0] wdata,
  // decoded strobes
  output xt_host_pkg::host_evt_s evt,
  output logic [DW-1:0] wdata_r
);

  logic ior_prev_r;
  logic iow_prev_r;
  logic dma_r;
  logic ctl_r;
  logic [1:0] port_r;
  wire strobe_low = ~bus.ior_n | ~bus.iow_n;
  wire dma_sel = ~bus.dack_n;
  wire ctl_sel = bus.dack_n & ~bus.cs_n;
  wire rd_end = bus.ior_n & ~ior_prev_r;
  wire wr_end = bus.iow_n & ~iow_prev_r;
  wire data_sel_r = dma_r | (ctl_r & (port_r == xt_host_pkg::PORT_DATA));

  // address and select are held from the strobe, ends use the held copy
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      ior_prev_r <= 1'b1;
      iow_prev_r <= 1'b1;
      dma_r <= 1'b0;
      ctl_r <= 1'b0;
      port_r <= 2'h0;
      wdata_r <= '0;
    end
    else
    begin
      ior_prev_r <= bus.ior_n;
      iow_prev_r <= bus.iow_n;
      if (strobe_low)
      begin
        dma_r <= dma_sel;
        ctl_r <= ctl_sel;
        port_r <= bus.addr;
      end
      if (~bus.iow_n)
        wdata_r <= wdata;
    end
  end

  assign evt.data_rd = rd_end & data_sel_r;
  assign evt.data_wr = wr_end & data_sel_r;
  assign evt.reset_wr = wr_end & ctl_r & ~dma_r
                        & (port_r == xt_host_pkg::PORT_STATUS);
  assign evt.select_wr = wr_end & ctl_r & ~dma_r
                         & (port_r == xt_host_pkg::PORT_SELECT);
  assign evt.enable_wr = wr_end & ctl_r & ~dma_r
                         & (port_r == xt_host_pkg::PORT_ENABLE);
  // live, not latched: the status read drives while the strobe is low
  assign evt.status_rd = ~bus.ior_n & ctl_sel
                         & (bus.addr == xt_host_pkg::PORT_STATUS);

endmodule
`default_nettype wire

//--- xt_host_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module xt_host_monitor #(
  parameter int DW = 8
) (
  // clock and resets
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic host_reset_input,
  input wire logic xt_mode_select,
  // host bus
  input wire logic host_cs_n,
  input wire logic host_dack_n,
  input wire logic [1:0] host_addr,
  input wire logic host_ior_n,
  input wire logic [DW-1:0] host_data_out,
  input wire logic host_data_oe_n,
  input wire logic host_dreq,
  input wire logic host_interrupt_output
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  AST_RSVD: assert property (host_data_out[7:6] == 2'h0)
    else $error("reserved status bits not zero");
  AST_DREQ_IMG: assert property
    (host_data_out[4] == $past(host_dreq))
    else $error("dma status bit differs from dreq pin");
  AST_DREQ_DATA: assert property (host_dreq |=> host_data_out[3] &&
    !host_data_out[2] && host_data_out[0])
    else $error("dreq outside a data phase byte request");
  AST_DACK: assert property (!host_dack_n |-> !host_dreq)
    else $error("dreq held during dack");
  AST_MODE: assert property (!xt_mode_select |->
    !host_dreq && host_data_oe_n)
    else $error("host port active with mode select off");
  AST_OE: assert property (host_data_oe_n == !(!host_ior_n &&
    !host_cs_n && host_dack_n && host_addr == 2'h1 && xt_mode_select))
    else $error("status drive enable wrong");
  AST_INT_IMG: assert property
    (host_data_out[5] == $past(host_interrupt_output))
    else $error("interrupt status bit differs from pin");
  AST_INT_SET: assert property ($rose(host_interrupt_output) |->
    host_data_out[3:0] == 4'hf)
    else $error("interrupt raised outside status phase");
  AST_HRST: assert property (host_reset_input |=>
    !host_interrupt_output && !host_dreq)
    else $error("host reset left interrupt or dreq");
endmodule
bind xt_host_status_handshake xt_host_monitor #(.DW(DW)) mon (
  .sys_clk(sys_clk),
  .rst(rst),
  .host_reset_input(host_reset_input),
  .xt_mode_select(xt_mode_select),
  .host_cs_n(host_cs_n),
  .host_dack_n(host_dack_n),
  .host_addr(host_addr),
  .host_ior_n(host_ior_n),
  .host_data_out(host_data_out),
  .host_data_oe_n(host_data_oe_n),
  .host_dreq(host_dreq),
  .host_interrupt_output(host_interrupt_output)
);
`default_nettype wire

//--- host_dma_model.sv
`timescale 1ns/100ps
`default_nettype none
module host_dma_model (
  // clock
  input wire logic sys_clk,
  // dma handshake
  input wire logic dreq,
  input wire logic [1:0] wait_cyc,
  output logic dack_n,
  output logic ior_n
);
  initial
  begin
    dack_n = 1'b1;
    ior_n = 1'b1;
    forever
    begin
      @(posedge sys_clk);
      if (dreq)
      begin
        repeat (wait_cyc) @(posedge sys_clk);
        dack_n <= 1'b0;
        @(posedge sys_clk);
        ior_n <= 1'b0;
        @(posedge sys_clk);
        ior_n <= 1'b1;
        @(posedge sys_clk);
        dack_n <= 1'b1;
        // let the request drop before looking again
        @(posedge sys_clk);
      end
    end
  end
endmodule
`default_nettype wire

//--- testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic hrst = 1'b0;
  logic mode = 1'b1;
  logic cs_n = 1'b1;
  logic [1:0] addr = 2'h0;
  logic tior = 1'b1;
  logic iow_n = 1'b1;
  logic [7:0] din = 8'h00;
  logic [2:0] ucp = 3'h0;
  logic [1:0] psel = 2'h0;
  logic [1:0] wc = 2'h0;
  logic mior;
  logic dack_n;
  logic bt;
  logic dreq;
  logic oe_n;
  logic [7:0] dout;
  logic irq;
  logic cst;
  logic abt;
  logic drv;
  logic [7:0] uwd;
  logic [7:0] wd;
  int starts = 0;
  int aborts = 0;
  int err_total = 0;
  int tests_run = 0;
  int n;
  int i;

  xt_host_status_handshake uut (
    .sys_clk(sys_clk),
    .rst(rst),
    .host_reset_input(hrst),
    .xt_mode_select(mode),
    .host_cs_n(cs_n),
    .host_dack_n(dack_n),
    .host_addr(addr),
    .host_ior_n(tior & mior),
    .host_iow_n(iow_n),
    .host_data_in(din),
    .host_data_out(dout),
    .host_data_oe_n(oe_n),
    .host_dreq(dreq),
    .host_interrupt_output(irq),
    .uc_phase_load(ucp[0]),
    .uc_phase_sel(psel),
    .uc_byte_ready(ucp[1]),
    .uc_cmd_done(ucp[2]),
    .uc_cmd_start(cst),
    .uc_byte_taken(bt),
    .uc_host_abort(abt),
    .uc_drive_select(drv),
    .uc_host_wdata(uwd)
  );

  host_dma_model host (
    .sys_clk(sys_clk),
    .dreq(dreq),
    .wait_cyc(wc),
    .dack_n(dack_n),
    .ior_n(mior)
  );

  initial
  begin
    forever
      #5 sys_clk = ~sys_clk;
  end

  // count local side pulses: command starts and aborts
  always @(posedge sys_clk)
  begin
    if (cst === 1'b1)
      starts <= starts + 1;
    if (abt === 1'b1)
      aborts <= aborts + 1;
  end

  task automatic cyc(input int c);
    repeat (c) @(posedge sys_clk);
  endtask

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    tests_run++;
    if (g !== e)
    begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    cyc(1);
    cs_n <= 1'b0;
    addr <= a;
    din <= d;
    iow_n <= 1'b0;
    cyc(1);
    iow_n <= 1'b1;
    cs_n <= 1'b1;
    cyc(2);
  endtask

  // z is the expected drive enable; the byte is only checked when driven
  task automatic rd(input logic [1:0] a, input logic [7:0] e, input logic z);
    cyc(2);
    cs_n <= 1'b0;
    addr <= a;
    tior <= 1'b0;
    cyc(2);
    chk({7'h0, oe_n}, {7'h0, z});
    if (!z)
      chk(dout, e);
    tior <= 1'b1;
    cs_n <= 1'b1;
  endtask

  // k bits: phase load, byte ready, command done
  task automatic uc(input logic [2:0] k, input logic [1:0] s);
    cyc(1);
    ucp <= k;
    psel <= s;
    cyc(1);
    ucp <= 3'h0;
    cyc(1);
  endtask

  task automatic note(input string s);
    $display("test %s done", s);
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial
  begin
    void'($urandom(90509));
    cyc(10);
    rst <= 1'b0;
    rd(2'h1, 8'h00, 1'b0);
    wd = 8'($urandom);
    wr(2'h2, wd);
    chk(uwd, wd);
    rd(2'h1, 8'h0c, 1'b0);
    wr(2'h2, 8'($urandom));
    rd(2'h1, 8'h0c, 1'b0);
    chk(8'(starts), 8'h01);
    for (i = 0; i < 4; i++)
    begin
      uc(3'h1, 2'(i));
      rd(2'h1, 8'h08 | 8'(i * 2), 1'b0);
    end
    note("phases");
    uc(3'h1, 2'h1);
    wr(2'h3, {5'($urandom), 3'h5});
    chk({7'h0, drv}, 8'h01);
    n = $urandom_range(4, 1);
    repeat (n)
    begin
      wc <= 2'($urandom);
      uc(3'h2, 2'h1);
      i = 0;
      while (bt !== 1'b1 && i < 40)
      begin
        cyc(1);
        i++;
      end
      chk({7'h0, bt}, 8'h01);
      rd(2'h1, 8'h0a, 1'b0);
    end
    wr(2'h3, 8'h00);
    chk({7'h0, drv}, 8'h00);
    uc(3'h2, 2'h1);
    rd(2'h1, 8'h0b, 1'b0);
    rd(2'h0, 8'h00, 1'b1);
    rd(2'h1, 8'h0a, 1'b0);
    uc(3'h1, 2'h0);
    uc(3'h2, 2'h0);
    wd = 8'($urandom);
    wr(2'h0, wd);
    chk(uwd, wd);
    rd(2'h1, 8'h08, 1'b0);
    note("transfers");
    wr(2'h3, 8'h02);
    uc(3'h1, 2'h3);
    uc(3'h2, 2'h3);
    rd(2'h1, 8'h2f, 1'b0);
    chk({7'h0, irq}, 8'h01);
    wr(2'h3, 8'h00);
    chk({7'h0, irq}, 8'h00);
    rd(2'h1, 8'h0f, 1'b0);
    wr(2'h3, 8'h02);
    rd(2'h1, 8'h2f, 1'b0);
    wr(2'h1, 8'($urandom));
    rd(2'h1, 8'h00, 1'b0);
    chk(8'(aborts), 8'h01);
    wr(2'h2, 8'h00);
    uc(3'h1, 2'h3);
    uc(3'h2, 2'h3);
    hrst <= 1'b1;
    cyc(1);
    hrst <= 1'b0;
    rd(2'h1, 8'h00, 1'b0);
    chk(8'(aborts), 8'h02);
    wr(2'h2, 8'h00);
    uc(3'h1, 2'h3);
    uc(3'h2, 2'h3);
    rd(2'h1, 8'h0f, 1'b0);
    uc(3'h4, 2'h0);
    rd(2'h1, 8'h00, 1'b0);
    mode <= 1'b0;
    wr(2'h2, 8'h00);
    rd(2'h1, 8'h00, 1'b1);
    mode <= 1'b1;
    rd(2'h1, 8'h00, 1'b0);
    chk(8'(starts), 8'h03);
    note("interrupts and modes");
    final_report();
  end

  initial
  begin
    cyc(5000);
    err_total++;
    final_report();
  end
endmodule
`default_nettype wire
